/* File: design/pfcd_bus_cycle.sv */
// ***************************************************************
// one asynchronous bus cycle: setup, strobe, hold
// ***************************************************************
module pfcd_bus_cycle (
   input  wire logic                    sys_clk,   // clock
   input  wire logic                    rst,       // sync reset
   input  wire logic                    start,     // begin a cycle
   input  wire logic                    is_write,  // write strobe instead of read
   input  wire logic [pfcd_pkg::cnt_w-1:0] strobe_len, // strobe width in cycles
   output logic                         strobe_we, // write strobe active
   output logic                         strobe_oe, // read strobe active
   output logic                         sample,    // last strobe cycle pulse
   output logic                         done       // cycle finished pulse
);
   typedef enum logic [1:0] {
      bc_idle = 2'b00, bc_setup = 2'b01, bc_strobe = 2'b10, bc_hold = 2'b11
   } pfcd_bc_e;

   pfcd_bc_e                     st_q, st_d;
   logic [pfcd_pkg::cnt_w-1:0]   cnt_q, cnt_d;
   logic                         wr_q, wr_d;

   // next state of the cycle sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      unique case (st_q)
         bc_idle: begin
            if (start) begin
               st_d = bc_setup;
               wr_d = is_write;
               cnt_d = pfcd_pkg::cnt_w'(pfcd_pkg::setup_cyc - 1);
            end
         end
         bc_setup: begin
            if (cnt_q == '0) begin
               st_d = bc_strobe;
               cnt_d = strobe_len - 8'h01;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         bc_strobe: begin
            if (cnt_q == '0) st_d = bc_hold;
            else cnt_d = cnt_q - 8'h01;
         end
         bc_hold: st_d = bc_idle;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= bc_idle;
         cnt_q <= '0;
         wr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
      end
   end

   assign strobe_we = (st_q == bc_strobe) && wr_q;
   assign strobe_oe = (st_q == bc_strobe) && !wr_q;
   assign sample = (st_q == bc_strobe) && (cnt_q == '0);
   assign done = (st_q == bc_hold);
endmodule : pfcd_bus_cycle

/* File: design/pfcd_host.sv */
module pfcd_host (
   input  wire logic        sys_clk,      // 100 MHz clock
   input  wire logic        rst,          // sync reset, active high
   input  wire logic        req_valid,    // operation request
   input  wire logic [3:0]  req_op,       // pfcd_op_e code
   input  wire logic [20:0] req_addr,     // target address
   input  wire logic [7:0]  req_data,     // data byte
   output logic             req_ready,    // idle, request accepted
   output logic             rsp_valid,    // operation complete pulse
   output logic [7:0]       rsp_data,     // read data
   output logic             rsp_locked,   // last lock read said locked
   output logic [20:0]      flash_addr,   // address pins
   output logic [7:0]       flash_dq_o,   // data out
   output logic             flash_dq_oe_n, // low while host drives dq
   input  wire logic [7:0]  flash_dq_i,   // data in
   output logic             flash_ce_n,   // chip select
   output logic             flash_oe_n,   // output enable
   output logic             flash_we_n,   // write strobe
   output logic             flash_rst_n   // hardware reset
);
   // ***************************************************************
   // pin input sync
   // ***************************************************************
   logic [7:0] dq_m_q, dq_s_q;
   always_ff @(posedge sys_clk) begin
      dq_m_q <= flash_dq_i;
      dq_s_q <= dq_m_q;
   end

   // ***************************************************************
   // sequencer
   // ***************************************************************
   typedef enum logic [2:0] {
      s_idle = 3'b000, s_issue = 3'b001, s_wait = 3'b010,
      s_rst = 3'b011, s_rhr = 3'b100, s_resp = 3'b101
   } pfcd_st_e;

   pfcd_st_e          st_q, st_d;
   pfcd_pkg::pfcd_op_e op_q, op_d;
   logic [2:0]        idx_q, idx_d;       // index of the current bus cycle
   logic [20:0]       addr_q, addr_d;
   logic [7:0]        wdat_q, wdat_d;
   logic [7:0]        rdat_q, rdat_d;
   logic              lock_q, lock_d;
   logic [pfcd_pkg::cnt_w-1:0] cnt_q, cnt_d;
   logic              bc_start, bc_we, bc_oe, bc_sample, bc_done;
   logic [2:0]        n_cyc;              // cycles in this operation
   logic              cyc_wr;
   logic [20:0]       cyc_addr;
   logic [7:0]        cyc_dat;
   logic [7:0]        final_code;

   // final command byte of the operation
   always_comb begin
      unique case (op_q)
         pfcd_pkg::op_program:   final_code = pfcd_pkg::code_program;
         pfcd_pkg::op_sector:    final_code = pfcd_pkg::code_sector;
         pfcd_pkg::op_block:     final_code = pfcd_pkg::code_block;
         pfcd_pkg::op_chip:      final_code = pfcd_pkg::code_chip;
         pfcd_pkg::op_query:     final_code = pfcd_pkg::code_query;
         pfcd_pkg::op_ident:     final_code = pfcd_pkg::code_ident;
         pfcd_pkg::op_sec_read:  final_code = pfcd_pkg::code_sec_read;
         pfcd_pkg::op_sec_prog:  final_code = pfcd_pkg::code_sec_prog;
         pfcd_pkg::op_sec_lock:  final_code = pfcd_pkg::code_sec_lock;
         default:                final_code = pfcd_pkg::code_exit;
      endcase
   end

   // build the address/data of bus cycle idx_q; command offsets drive
   // only the low twelve bits, upper bits come from the request
   always_comb begin
      n_cyc = 3'd3;
      cyc_wr = 1'b1;
      cyc_addr = {addr_q[20:12], pfcd_pkg::ofs_unlock1};
      cyc_dat = pfcd_pkg::code_unlock1;
      unique case (op_q)
         pfcd_pkg::op_program, pfcd_pkg::op_sec_prog, pfcd_pkg::op_sec_lock: n_cyc = 3'd4;
         pfcd_pkg::op_sector, pfcd_pkg::op_block, pfcd_pkg::op_chip: n_cyc = 3'd6;
         pfcd_pkg::op_exit, pfcd_pkg::op_read: n_cyc = 3'd1;
         default: n_cyc = 3'd3;
      endcase
      if (op_q == pfcd_pkg::op_read) begin
         cyc_wr = 1'b0;
         cyc_addr = addr_q;
      end else if (op_q == pfcd_pkg::op_exit) begin
         cyc_addr = addr_q;                   // any address
         cyc_dat = pfcd_pkg::code_exit;
      end else begin
         unique case (idx_q)
            3'd1, 3'd4: begin
               cyc_addr = {addr_q[20:12], pfcd_pkg::ofs_unlock2};
               cyc_dat = pfcd_pkg::code_unlock2;
            end
            3'd2: cyc_dat = (n_cyc == 3'd6) ? pfcd_pkg::code_erase : final_code;
            3'd3: begin
               // fourth write: data, lock code or first unlock again
               if (op_q == pfcd_pkg::op_sec_lock) begin
                  cyc_addr = addr_q;
                  cyc_dat = pfcd_pkg::code_lock_dat;
               end else if (n_cyc == 3'd4) begin
                  cyc_addr = addr_q;
                  cyc_dat = wdat_q;
               end
            end
            3'd5: begin
               // region from the final write's address
               if (op_q != pfcd_pkg::op_chip) cyc_addr = addr_q;
               cyc_dat = final_code;
            end
            default: ;
         endcase
      end
   end

   function automatic logic pfcd_op_is_rst(input logic [3:0] op);
      pfcd_op_is_rst = (op == pfcd_pkg::op_hw_reset);
   endfunction : pfcd_op_is_rst

   // operation sequencing
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      idx_d = idx_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      lock_d = lock_q;
      cnt_d = cnt_q;
      bc_start = 1'b0;
      unique case (st_q)
         s_idle: begin
            if (req_valid) begin
               op_d = pfcd_pkg::pfcd_op_e'(req_op);
               addr_d = req_addr;
               wdat_d = req_data;
               idx_d = 3'd0;
               if (pfcd_op_is_rst(req_op)) begin
                  st_d = s_rst;
                  cnt_d = pfcd_pkg::cnt_w'(pfcd_pkg::rst_cyc - 1);
               end else begin
                  st_d = s_issue;
               end
            end
         end
         s_issue: begin
            bc_start = 1'b1;
            st_d = s_wait;
         end
         s_wait: begin
            if (bc_sample && !cyc_wr) begin
               rdat_d = dq_s_q;
               if (addr_q == pfcd_pkg::addr_lock_st)
                  lock_d = !dq_s_q[pfcd_pkg::lock_bit];
            end
            if (bc_done) begin
               if (idx_q == n_cyc - 3'd1) begin
                  st_d = s_resp;
               end else begin
                  idx_d = idx_q + 3'd1;
                  st_d = s_issue;
               end
            end
         end
         s_rst: begin
            if (cnt_q == '0) begin
               st_d = s_rhr;
               cnt_d = pfcd_pkg::cnt_w'(pfcd_pkg::rhr_cyc - 1);
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         s_rhr: begin
            if (cnt_q == '0) st_d = s_resp;    // caller may now reissue aborted work
            else cnt_d = cnt_q - 8'h01;
         end
         s_resp: st_d = s_idle;
         default: st_d = s_idle;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= s_idle;
         op_q <= pfcd_pkg::op_read;
         idx_q <= 3'd0;
         addr_q <= '0;
         wdat_q <= '0;
         rdat_q <= '0;
         lock_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         idx_q <= idx_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         lock_q <= lock_d;
         cnt_q <= cnt_d;
      end
   end

   pfcd_bus_cycle u_cycle (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .start      (bc_start),
      .is_write   (cyc_wr),
      .strobe_len (cyc_wr ? pfcd_pkg::cnt_w'(pfcd_pkg::strobe_cyc)
                          : pfcd_pkg::cnt_w'(pfcd_pkg::read_cyc)),
      .strobe_we  (bc_we),
      .strobe_oe  (bc_oe),
      .sample     (bc_sample),
      .done       (bc_done)
   );

   // ***************************************************************
   // registered pins and answers
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flash_addr <= '0;
         flash_dq_o <= '0;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_rst_n <= 1'b1;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_locked <= 1'b0;
      end else begin
         flash_addr <= cyc_addr;
         flash_dq_o <= cyc_dat;
         flash_dq_oe_n <= !(st_q == s_wait && cyc_wr);
         flash_ce_n <= !(st_q == s_wait || st_q == s_issue);
         flash_oe_n <= !bc_oe;                      // never low with we
         flash_we_n <= !bc_we;
         flash_rst_n <= !(st_q == s_rst);
         req_ready <= (st_d == s_idle);
         rsp_valid <= (st_q == s_resp);
         rsp_data <= rdat_q;
         rsp_locked <= lock_q;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   we_oe_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
      !(!flash_we_n && !flash_oe_n)) else $error("write and read strobe together");
   rst_width_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(flash_rst_n) |-> !flash_rst_n [*8]) else $error("reset pulse short");
   rst_rhr_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(flash_rst_n) |-> flash_oe_n [*5]) else $error("read too soon after reset");
   unlock1_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st_q == s_wait && bc_we && idx_q == 3'd0 && op_q != pfcd_pkg::op_exit
       && op_q != pfcd_pkg::op_read) |-> cyc_dat == 8'haa && cyc_addr[11:0] == 12'haaa)
      else $error("bad first unlock");
   unlock2_a: assert property (@(posedge sys_clk) disable iff (rst)
      (bc_we && idx_q == 3'd1) |-> cyc_dat == 8'h55 && cyc_addr[11:0] == 12'h555)
      else $error("bad second unlock");
   erase_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
      (bc_we && idx_q == 3'd2 && op_q == pfcd_pkg::op_chip) |-> cyc_dat == 8'h80)
      else $error("erase setup missing");
   chip_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
      (bc_we && idx_q == 3'd5 && op_q == pfcd_pkg::op_chip)
      |-> cyc_addr[11:0] == 12'haaa && cyc_dat == 8'h10) else $error("bad chip erase");
   lock_dat_a: assert property (@(posedge sys_clk) disable iff (rst)
      (bc_we && idx_q == 3'd3 && op_q == pfcd_pkg::op_sec_lock) |-> cyc_dat == 8'h00)
      else $error("bad lock-out data");
   resp_a: assert property (@(posedge sys_clk) disable iff (rst)
      rsp_valid |-> flash_ce_n && flash_we_n) else $error("bus held at answer");
   cov_prog_c: cover property (@(posedge sys_clk) st_q == s_resp && op_q == pfcd_pkg::op_program);
   cov_chip_c: cover property (@(posedge sys_clk) st_q == s_resp && op_q == pfcd_pkg::op_chip);
   cov_rst_c:  cover property (@(posedge sys_clk) st_q == s_resp && op_q == pfcd_pkg::op_hw_reset);
endmodule : pfcd_host

/* File: dv/pfcd_flash_model.sv */
// ****************************************
// behavioural flash device on the far side
// ****************************************
module pfcd_flash_model #(
   parameter logic [7:0] man_code  = 8'h3a, // arbitrary value
   parameter logic [7:0] part_code = 8'h6d, // arbitrary value
   parameter int         prog_ns   = 1000,  // internal program time
   parameter int         erase_ns  = 3000,  // internal erase time
   parameter int         acc_ns    = 30     // read access delay
) (
   input  wire logic        ce_n,    // chip select
   input  wire logic        oe_n,    // output enable
   input  wire logic        we_n,    // write strobe
   input  wire logic        rst_n,   // hardware reset
   input  wire logic [20:0] addr,    // address pins
   input  wire logic [7:0]  dq_host, // host data
   input  wire logic        dq_oe_n, // host drives when low
   output logic      [7:0]  dq_bus   // resolved data wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [int];
   logic [7:0]  sec [int];
   logic [7:0]  rd_now = 8'h00, rd_dly, flt = 8'h5a, wd, last_d = 8'hff;
   logic [20:0] wa, pa = 21'h000000;
   logic        locked = 1'b0, ok = 1'b0, tog = 1'b0;
   int          stg = 0, mode = 0; // powers up in array mode
   time         busy_until = 0, rst_low = 0, rst_rise = 0;

   // a short pulse is not a reset at all
   always @(negedge rst_n) rst_low = $time;
   always @(posedge rst_n) begin
      if ($time - rst_low >= pfcd_pkg::reset_pulse_min_time_ns) begin
         stg = 0;
         mode = 0;
         if ($time < busy_until) mem[pa] = 8'h5a; // aborted byte is garbage
         busy_until = 0;
      end
      rst_rise = $time;
   end

   // one read per enable fall; status toggles while busy
   always @(negedge oe_n) begin
      #1;
      tog = ~tog;
      if ($time < rst_rise + pfcd_pkg::reset_high_to_read_time_ns) rd_now = {8{tog}};
      else if ($time < busy_until) rd_now = {~last_d[7], tog, 6'h00};
      else case (mode)
         1: rd_now = (addr[7:0] == 8'h10) ? 8'h51 : (addr[7:0] == 8'h11) ? 8'h52 :
                     (addr[7:0] == 8'h12) ? 8'h59 : 8'h00;
         2: rd_now = addr[0] ? part_code : man_code;
         3: rd_now = (addr[7:0] == 8'hff) ? {4'hf, ~locked, 3'h7} :
                     sec.exists(addr[7:0]) ? sec[addr[7:0]] : 8'hff;
         default: rd_now = mem.exists(addr) ? mem[addr] : 8'hff;
      endcase
   end
   assign #(acc_ns) rd_dly = rd_now;

   // a released wire keeps changing so a late sample cannot pass
   always @(posedge oe_n or posedge dq_oe_n) flt = ~flt;
   assign dq_bus = !dq_oe_n ? ((!oe_n && !ce_n) ? 8'hxx : dq_host) :
                   (!oe_n && !ce_n && rst_n) ? rd_dly : flt;

   // writes latch at strobe fall and act at strobe rise
   always @(negedge we_n) begin
      wa = addr;
      wd = dq_oe_n ? flt : dq_host;
      ok = !ce_n && oe_n && rst_n;
   end
   always @(posedge we_n) if (ok) wr(wa, wd);

   task automatic wr(input logic [20:0] a, input logic [7:0] d);
      logic        good, hit;
      int          nxt;
      logic [20:0] m;
      good = 1'b1;
      nxt = 0;
      m = 21'h000000;
      hit = (a[11:0] == 12'haaa);
      if ($time < busy_until) return;
      case (stg)
         0: begin
            if (d == 8'hf0) mode = 0;
            else if (hit && d == 8'haa) nxt = 1;
         end
         1, 5: if (a[11:0] == 12'h555 && d == 8'h55) nxt = stg + 1; else good = 0;
         4: if (hit && d == 8'haa) nxt = 5; else good = 0;
         2: begin
            if (!hit) good = 0;
            else case (d)
               8'ha0: nxt = 3;
               8'h80: nxt = 4;
               8'ha5: nxt = 7;
               8'h85: nxt = 8;
               8'h98: mode = 1;
               8'h90: mode = 2;
               8'h88: mode = 3;
               8'hf0: mode = 0;
               default: good = 0;
            endcase
         end
         3: begin
            mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d;
            pa = a;
            last_d = d;
            busy_until = $time + prog_ns;
         end
         6: begin
            if (d == 8'h50) m = 21'h1ff000;
            else if (d == 8'h30) m = 21'h1f0000;
            else if (d != 8'h10 || !hit) good = 0;
            if (good) begin
               foreach (mem[k]) if ((21'(k) & m) == (a & m)) mem[k] = 8'hff;
               last_d = 8'h00;
               busy_until = $time + erase_ns;
            end
         end
         7: begin
            if (a[4] && !locked)
               sec[a[7:0]] = (sec.exists(a[7:0]) ? sec[a[7:0]] : 8'hff) & d;
            last_d = d;
            busy_until = $time + prog_ns;
         end
         8: if (d == 8'h00) locked = 1'b1; else good = 0;
         default: good = 0;
      endcase
      if (!good) mode = 0;
      stg = nxt;
   endtask : wr
endmodule : pfcd_flash_model

/* File: dv/test_parallel_flash_command_decoder.sv */
// ****************************************
// self-checking bench for the flash host
// ****************************************
module test_parallel_flash_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
   logic [3:0]  req_op = 4'h0;
   logic [20:0] req_addr = 21'h000000;
   logic [7:0]  req_data = 8'h00;
   logic        req_ready, rsp_valid, rsp_locked, dq_oe_n, ce_n, oe_n, we_n, rst_n;
   logic [7:0]  rsp_data, dq_o, dq_bus;
   logic [20:0] f_addr;
   int          bad_count = 0, total_checks = 0;
   logic [7:0]  ref_mem [int];
   logic [20:0] offs [3] = '{21'h000000, 21'h001000, 21'h010000};
   logic [20:0] masks [3] = '{21'h1ff000, 21'h1f0000, 21'h000000};

   pfcd_host u_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_locked(rsp_locked), .flash_addr(f_addr), .flash_dq_o(dq_o),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_bus), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_rst_n(rst_n));
   pfcd_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(rst_n),
      .addr(f_addr), .dq_host(dq_o), .dq_oe_n(dq_oe_n), .dq_bus(dq_bus));

   // free-running 100 MHz clock
   initial forever #5 sys_clk = ~sys_clk;

   function automatic logic [7:0] rr(input logic [20:0] a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'hff;
   endfunction : rr

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one request, held until the idle edge takes it
   task automatic do_op(input pfcd_pkg::pfcd_op_e op, input logic [20:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 100) begin
         bad_count++;
         $display("BAD %0t never ready", $time);
      end
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 1000);
      if (n >= 1000) begin
         bad_count++;
         $display("BAD %0t no response", $time);
      end
   endtask : do_op

   task automatic rd(input logic [20:0] a, input logic [7:0] exp);
      do_op(pfcd_pkg::op_read, a, 8'h00);
      chk(rsp_data, exp);
   endtask : rd

   // toggle polling: done when two reads agree
   task automatic poll(input logic [20:0] a);
      logic [7:0] prev;
      int         n;
      n = 0;
      do_op(pfcd_pkg::op_read, a, 8'h00);
      do begin
         prev = rsp_data;
         do_op(pfcd_pkg::op_read, a, 8'h00);
         n++;
      end while (rsp_data !== prev && n < 100);
      if (n >= 100) begin
         bad_count++;
         $display("BAD %0t poll stuck", $time);
      end
   endtask : poll

   task automatic report_and_stop;
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // watchdog sized well above the expected run of some 50 us
   initial begin
      #500000;
      bad_count++;
      $display("BAD %0t watchdog", $time);
      report_and_stop();
   end

   // main sequence
   initial begin
      logic [20:0] a, p;
      logic [7:0]  d;
      void'($urandom(81401));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      do_op(pfcd_pkg::op_ident, 21'h000000, 8'h00);
      rd(21'h000000, 8'h3a);
      rd(21'h000001, 8'h6d);
      do_op(pfcd_pkg::op_exit_long, 21'h000000, 8'h00);
      rd(21'h000001, 8'hff);
      do_op(pfcd_pkg::op_query, 21'h1ff000, 8'h00);
      rd(21'h000010, 8'h51);
      rd(21'h000011, 8'h52);
      rd(21'h000012, 8'h59);
      do_op(pfcd_pkg::op_exit, 21'($urandom), 8'h00);
      rd(21'h000010, 8'hff);
      do_op(pfcd_pkg::op_sec_read, 21'h000000, 8'h00);
      rd(21'h0000ff, 8'hff);
      chk({7'h00, rsp_locked}, 8'h00);
      do_op(pfcd_pkg::op_exit, 21'h000000, 8'h00);
      do_op(pfcd_pkg::op_sec_prog, 21'h000013, 8'h3c);
      poll(21'h000013);
      do_op(pfcd_pkg::op_sec_lock, 21'($urandom), 8'h00);
      do_op(pfcd_pkg::op_sec_prog, 21'h000013, 8'h00);
      poll(21'h000013);
      for (int i = 0; i < 6; i++) begin
         a = (i == 5) ? a : 21'($urandom);
         d = 8'($urandom);
         do_op(pfcd_pkg::op_program, a, d);
         ref_mem[a] = rr(a) & d;
         poll(a);
         rd(a, rr(a));
      end
      p = 21'h0a3123;
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 3; j++) begin
            do_op(pfcd_pkg::op_program, p ^ offs[j], 8'h00);
            ref_mem[p ^ offs[j]] = 8'h00;
            poll(p ^ offs[j]);
         end
         do_op(pfcd_pkg::pfcd_op_e'(k + 1), p, 8'h00);
         foreach (ref_mem[x]) if ((21'(x) & masks[k]) == (p & masks[k])) ref_mem[x] = 8'hff;
         poll(p);
         for (int j = 0; j < 3; j++) rd(p ^ offs[j], rr(p ^ offs[j]));
      end
      do_op(pfcd_pkg::op_sec_read, 21'h000000, 8'h00);
      rd(21'h000013, 8'h3c);
      rd(21'h0000ff, 8'hf7);
      chk({7'h00, rsp_locked}, 8'h01);
      do_op(pfcd_pkg::op_hw_reset, 21'h000000, 8'h00);
      rd(21'h0000ff, rr(21'h0000ff));
      do_op(pfcd_pkg::op_program, p, 8'h00);
      do_op(pfcd_pkg::op_hw_reset, 21'h000000, 8'h00);
      rd(p ^ offs[2], rr(p ^ offs[2]));
      do_op(pfcd_pkg::op_program, p, 8'h00);
      ref_mem[p] = 8'h00;
      poll(p);
      rd(p, rr(p));
      report_and_stop();
   end
endmodule : test_parallel_flash_command_decoder

/* File: include/pfcd_pkg.sv */
package pfcd_pkg;
   // ***************************************************************
   // command offsets and codes
   // ***************************************************************
   localparam logic [11:0] ofs_unlock1   = 12'haaa;
   localparam logic [11:0] ofs_unlock2   = 12'h555;
   localparam logic [7:0]  code_unlock1  = 8'haa;
   localparam logic [7:0]  code_unlock2  = 8'h55;
   localparam logic [7:0]  code_program  = 8'ha0;
   localparam logic [7:0]  code_erase    = 8'h80;
   localparam logic [7:0]  code_sector   = 8'h50;
   localparam logic [7:0]  code_block    = 8'h30;
   localparam logic [7:0]  code_chip     = 8'h10;
   localparam logic [7:0]  code_query    = 8'h98;
   localparam logic [7:0]  code_ident    = 8'h90;
   localparam logic [7:0]  code_exit     = 8'hf0;
   localparam logic [7:0]  code_sec_prog = 8'ha5;
   localparam logic [7:0]  code_sec_lock = 8'h85;
   localparam logic [7:0]  code_lock_dat = 8'h00;
   localparam logic [7:0]  code_sec_read = 8'h88;
   localparam logic [20:0] addr_lock_st  = 21'h0000ff;
   localparam int          lock_bit      = 3;

   // ***************************************************************
   // host operations
   // ***************************************************************
   typedef enum logic [3:0] {
      op_program  = 4'h0,
      op_sector   = 4'h1,
      op_block    = 4'h2,
      op_chip     = 4'h3,
      op_query    = 4'h4,
      op_ident    = 4'h5,
      op_sec_read = 4'h6,
      op_sec_prog = 4'h7,
      op_sec_lock = 4'h8,
      op_exit     = 4'h9,
      op_exit_long = 4'ha,
      op_read     = 4'hb,
      op_hw_reset = 4'hc
   } pfcd_op_e;

   // ***************************************************************
   // bus timing, 100 MHz sys_clk
   // ***************************************************************
   localparam int clk_period_ns  = 10;
   localparam int setup_time_ns  = 30;   // address/data to strobe
   localparam int strobe_time_ns = 40;   // strobe low width
   localparam int read_cycle_time_ns = 70;
   localparam int reset_pulse_min_time_ns = 500;
   localparam int reset_high_to_read_time_ns = 50;
   localparam int setup_cyc  = (setup_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int strobe_cyc = (strobe_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int read_cyc   = (read_cycle_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int rst_cyc    = (reset_pulse_min_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int rhr_cyc    = (reset_high_to_read_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int cnt_w      = 8;
endpackage : pfcd_pkg
